/* event_map.svh */
// Constants for the event channel: action codes, hold codes, defaults, widths
// Assumes inclusion by the package, the checker and the bench
`ifndef EVENT_MAP_SVH
`define EVENT_MAP_SVH
`define EV_DATA_W 16
`define EV_TYPE_W 4
`define EV_HOLD_W 2
`define EV_TYPE_NONE 4'h0
`define EV_TYPE_DEV_HI 4'h1
`define EV_TYPE_DEV_LO 4'h2
`define EV_TYPE_DEV_HL 4'h3
`define EV_TYPE_BAND 4'h4
`define EV_TYPE_PV_HI 4'h5
`define EV_TYPE_PV_LO 4'h6
`define EV_TYPE_SV_HI 4'h7
`define EV_TYPE_SV_LO 4'h8
`define EV_TYPE_UNUSED 4'h9
`define EV_TYPE_HEAT_HI 4'ha
`define EV_TYPE_HEAT_LO 4'hb
`define EV_TYPE_COOL_HI 4'hc
`define EV_TYPE_COOL_LO 4'hd
`define EV_HOLD_OFF 2'h0
`define EV_HOLD_ON 2'h1
`define EV_HOLD_REHOLD 2'h2
`define EV_TYPE_RESET `EV_TYPE_NONE
`define EV_HOLD_RESET `EV_HOLD_OFF
`define EV_GAP_RESET 16'h0002
`define EV_ZERO 16'h0000
`define ADDR_TYPE 4'h0
`define ADDR_HOLD 4'h4
`define ADDR_SETVAL 4'h8
`define ADDR_GAP 4'hc
`define ADDR_W 4
`define ADDR_LSB 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STATUS_HOLD_BIT 1
`define STATUS_EVENT_BIT 0
`endif

/* event_pkg.sv */
// Types shared by the event channel
// Assumes event_map.svh in the same folder
`include "event_map.svh"
package event_pkg;
   typedef struct packed {
      logic signed [`EV_DATA_W-1:0] measured_value;
      logic signed [`EV_DATA_W-1:0] control_setpoint;
      logic signed [`EV_DATA_W-1:0] setpoint_monitor;
      logic signed [`EV_DATA_W-1:0] heat_side_output;
      logic signed [`EV_DATA_W-1:0] cool_side_output;
      logic signed [`EV_DATA_W-1:0] feedback_resistance_input;
   } process_values_t;
   typedef struct packed {
      logic sample;
      logic run;
      logic fbr_in_use;
      logic rate_limiter_on;
      logic remote_mode;
   } process_status_t;
   typedef enum logic [1:0] {st_idle, st_ready, st_resp} bus_state_t;
endpackage

/* event_type_hold_logic.sv */
// Event evaluation with hold and re-hold for one event channel, AXI4-Lite setup
// Assumes process values and status synchronous to aclk, sample a one-cycle pulse
//
// Operation
// - Decode action codes zero through thirteen
// - Action type resets to none
// - Deviation types compare measured minus monitored setpoint
// - Process types compare measured value directly
// - Setpoint types compare control setpoint
// - Output types compare heat or cool output
// - Feedback input replaces heat output when used
// - Setpoint types are never held
// - Hold code zero off, one hold, two rehold
// - Hold after power-on until non-event range
// - Hold again on every stop to run
// - Hold code two rearms on setpoint change
// - Rate limiter or remote mode disables rehold
// - Differential gap prevents output chatter
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module event_type_hold_logic
   import event_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire process_values_t values,
   input wire process_status_t status,
   output logic event_out
);
   logic [`EV_TYPE_W-1:0] action_type;
   logic [`EV_HOLD_W-1:0] hold_mode;
   logic signed [`EV_DATA_W-1:0] event_setval;
   logic [`EV_DATA_W-1:0] diff_gap;
   logic hold_flag;
   logic event_state;
   logic run_prev;
   logic signed [`EV_DATA_W-1:0] sv_prev;
   logic sv_seen;
   bus_state_t wr_state;
   logic aw_taken;
   logic w_taken;
   logic [`ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Register decode shared by the read and write paths
   function automatic logic addr_ok(input logic [`ADDR_W-1:0] a);
      addr_ok = (a == `ADDR_TYPE) || (a == `ADDR_HOLD) || (a == `ADDR_SETVAL) ||
                (a == `ADDR_GAP);
   endfunction

   // Byte lanes of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // Write channel: address and data in either order, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= st_idle;
         aw_taken <= 1'b0;
         w_taken <= 1'b0;
         aw_addr <= `ADDR_LSB;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         case (wr_state)
            st_idle: begin
               s_axi_awready <= 1'b1;
               s_axi_wready <= 1'b1;
               aw_taken <= 1'b0;
               w_taken <= 1'b0;
               wr_state <= st_ready;
            end
            st_ready: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  aw_addr <= s_axi_awaddr[`ADDR_W-1:0];
                  aw_taken <= 1'b1;
                  s_axi_awready <= 1'b0;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  w_data <= s_axi_wdata;
                  w_strb <= s_axi_wstrb;
                  w_taken <= 1'b1;
                  s_axi_wready <= 1'b0;
               end
               if ((aw_taken || (s_axi_awvalid && s_axi_awready)) &&
                   (w_taken || (s_axi_wvalid && s_axi_wready))) begin
                  s_axi_awready <= 1'b0;
                  s_axi_wready <= 1'b0;
                  wr_state <= st_resp;
               end
            end
            st_resp: begin
               if (!s_axi_bvalid) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= addr_ok(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
               end else if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_state <= st_idle;
               end
            end
            default: begin
               wr_state <= st_idle;
            end
         endcase
      end
   end

   // One store strobe per write, in the cycle before bvalid rises
   logic do_write;
   assign do_write = (wr_state == st_resp) && !s_axi_bvalid;

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         action_type <= `EV_TYPE_RESET;
         hold_mode <= `EV_HOLD_RESET;
         event_setval <= `EV_ZERO;
         diff_gap <= `EV_GAP_RESET;
      end else if (do_write) begin
         case (aw_addr)
            `ADDR_TYPE: begin
               if (w_strb[0]) begin
                  action_type <= w_data[`EV_TYPE_W-1:0];
               end
            end
            `ADDR_HOLD: begin
               if (w_strb[0]) begin
                  hold_mode <= w_data[`EV_HOLD_W-1:0];
               end
            end
            `ADDR_SETVAL: begin
               event_setval <= merge16(event_setval, w_data, w_strb);
            end
            `ADDR_GAP: begin
               diff_gap <= merge16(diff_gap, w_data, w_strb);
            end
            default: begin
            end
         endcase
      end
   end

   // Read word assembled from the registers
   logic [31:0] read_word;
   always_comb begin
      case (s_axi_araddr[`ADDR_W-1:0])
         `ADDR_TYPE: read_word = {hold_flag, event_state, 26'h0, action_type};
         `ADDR_HOLD: read_word = {30'h0, hold_mode};
         `ADDR_SETVAL: read_word = {16'h0000, event_setval};
         `ADDR_GAP: read_word = {16'h0000, diff_gap};
         default: read_word = 32'h0000_0000;
      endcase
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= addr_ok(s_axi_araddr[`ADDR_W-1:0]) ? `RESP_OKAY : `RESP_SLVERR;
         s_axi_rdata <= read_word;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // Comparison with differential gap
   logic signed [`EV_DATA_W:0] deviation;
   logic signed [`EV_DATA_W:0] abs_dev;
   logic signed [`EV_DATA_W:0] monitored;
   logic signed [`EV_DATA_W:0] thr;
   logic signed [`EV_DATA_W:0] gap;
   logic signed [`EV_DATA_W-1:0] heat_value;
   logic high_sense;
   logic band_sense;
   logic in_event;
   logic holdable;
   logic valid_type;

   always_comb begin
      heat_value = status.fbr_in_use ? values.feedback_resistance_input
                                     : values.heat_side_output;
      deviation = {values.measured_value[`EV_DATA_W-1], values.measured_value} -
                  {values.setpoint_monitor[`EV_DATA_W-1], values.setpoint_monitor};
      abs_dev = deviation[`EV_DATA_W] ? -deviation : deviation;
      thr = {event_setval[`EV_DATA_W-1], event_setval};
      gap = {1'b0, diff_gap};
      monitored = deviation;
      high_sense = 1'b1;
      band_sense = 1'b0;
      valid_type = 1'b1;
      holdable = 1'b1;
      case (action_type)
         `EV_TYPE_DEV_HI: monitored = deviation;
         `EV_TYPE_DEV_LO: begin
            monitored = deviation;
            high_sense = 1'b0;
         end
         `EV_TYPE_DEV_HL: monitored = abs_dev;
         `EV_TYPE_BAND: begin
            monitored = abs_dev;
            band_sense = 1'b1;
         end
         `EV_TYPE_PV_HI: monitored = {values.measured_value[`EV_DATA_W-1],
                                      values.measured_value};
         `EV_TYPE_PV_LO: begin
            monitored = {values.measured_value[`EV_DATA_W-1], values.measured_value};
            high_sense = 1'b0;
         end
         `EV_TYPE_SV_HI: begin
            monitored = {values.control_setpoint[`EV_DATA_W-1], values.control_setpoint};
            holdable = 1'b0;
         end
         `EV_TYPE_SV_LO: begin
            monitored = {values.control_setpoint[`EV_DATA_W-1], values.control_setpoint};
            high_sense = 1'b0;
            holdable = 1'b0;
         end
         `EV_TYPE_HEAT_HI: monitored = {heat_value[`EV_DATA_W-1], heat_value};
         `EV_TYPE_HEAT_LO: begin
            monitored = {heat_value[`EV_DATA_W-1], heat_value};
            high_sense = 1'b0;
         end
         `EV_TYPE_COOL_HI: monitored = {values.cool_side_output[`EV_DATA_W-1],
                                        values.cool_side_output};
         `EV_TYPE_COOL_LO: begin
            monitored = {values.cool_side_output[`EV_DATA_W-1],
                         values.cool_side_output};
            high_sense = 1'b0;
         end
         default: begin
            valid_type = 1'b0;
            holdable = 1'b0;
         end
      endcase
      // Asserting edge at threshold, past it for the band type; release past threshold by the gap
      if (band_sense) begin
         in_event = event_state ? (monitored >= thr - gap) : (monitored > thr);
      end else if (high_sense) begin
         in_event = event_state ? (monitored > thr - gap) : (monitored >= thr);
      end else begin
         in_event = event_state ? (monitored < thr + gap) : (monitored <= thr);
      end
      in_event = in_event && valid_type;
   end

   // Hold state: run edges on every clock, the rest once per sample
   logic sv_changed;
   logic rehold_ok;
   logic run_rise;
   logic rearm;
   assign sv_changed = sv_seen && (values.control_setpoint != sv_prev);
   assign rehold_ok = (hold_mode == `EV_HOLD_REHOLD) && !status.rate_limiter_on &&
                      !status.remote_mode;
   assign run_rise = status.run && !run_prev;
   assign rearm = sv_changed && rehold_ok;

   // Run level tracked on every clock so a short stop between samples still holds
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_prev <= 1'b0;
      end else begin
         run_prev <= status.run;
      end
   end

   // Setpoint seen at the previous sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sv_prev <= `EV_ZERO;
         sv_seen <= 1'b0;
      end else if (status.sample) begin
         sv_prev <= values.control_setpoint;
         sv_seen <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_flag <= 1'b1;
      end else if (run_rise) begin
         hold_flag <= 1'b1;
      end else if (status.sample) begin
         if (rearm) begin
            hold_flag <= 1'b1;
         end else if (!in_event) begin
            hold_flag <= 1'b0;
         end
      end
   end

   // Hold ignored for setpoint types and hold code zero; a new hold counts at once
   logic hold_active;
   assign hold_active = (hold_flag || run_rise || rearm) && holdable &&
                        (hold_mode != `EV_HOLD_OFF);

   // Event result registered once per sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_state <= 1'b0;
         event_out <= 1'b0;
      end else if (status.sample) begin
         event_state <= in_event;
         event_out <= in_event && !hold_active;
      end
   end
endmodule

/* event_hold_checker_properties.sv */
// Concurrent checks on the event channel ports: bus handshakes, sample timing
// Assumes a bind to event_type_hold_logic in one aclk domain
`timescale 1ns/1ns
`include "event_map.svh"
module event_hold_checker
   import event_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire process_status_t status,
   input wire logic event_out
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_in_two;
      ##2 s_axi_bvalid;
   endsequence
   a_write_answer: assert property (wr_taken |-> resp_in_two)
      else $error("write response not two cycles after take");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid kept after handshake");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after take");
   a_read_bad: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
      |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_read_ok: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] == 2'h0
      |=> s_axi_rresp == `RESP_OKAY)
      else $error("mapped read refused");
   a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready while read data pending");
   a_event_on_sample: assert property (!status.sample |=> $stable(event_out))
      else $error("event changed without a sample");
endmodule

/* tb_event_type_hold_logic.sv */
// Self-checking bench for the event channel: register access, types, hold
// Assumes the design package and header in the same folder
`timescale 1ns/1ns
`include "event_map.svh"
module tb_event_type_hold_logic;
   import event_pkg::*;
   logic aclk = 0, aresetn = 0, samp_d = 0, lo;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, event_out;
   process_values_t v = '0, p;
   process_status_t st = 5'h08;
   logic [15:0] x;
   int err_count = 0, compares = 0;
   logic [63:0] rd_q[$];
   logic ev_q[$];
   event_type_hold_logic uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .values(v), .status(st), .event_out(event_out));
   always #10 aclk = ~aclk;
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   always @(posedge aclk) begin
      samp_d <= st.sample;
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         check("rdata", s_axi_rdata & rd_q[0][63:32], rd_q[0][31:0]);
         rd_q.delete(0);
      end
      if (samp_d) check("event_out", {31'h0, event_out}, {31'h0, ev_q.pop_front()});
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic aw, w;
      aw = 0;
      w = 0;
      s_axi_awaddr <= {28'h0, a};
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(aw && w)) begin
         @(posedge aclk);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         if (aw) s_axi_awvalid <= 0;
         if (w) s_axi_wvalid <= 0;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, m, input int lag = 0);
      s_axi_araddr <= {28'h0, a};
      s_axi_arvalid <= 1;
      s_axi_rready <= (lag == 0);
      rd_q.push_back({m, e});
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      repeat (lag) @(posedge aclk);
      s_axi_rready <= 1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask
   task automatic smp(input logic e);
      v <= p;
      repeat (2) @(posedge aclk);
      ev_q.push_back(e);
      st.sample <= 1;
      @(posedge aclk);
      st.sample <= 0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic pv(input logic [15:0] m, input logic e);
      p.measured_value = m;
      smp(e);
   endtask
   task automatic run_cycle;
      st.run <= 0;
      repeat (2) @(posedge aclk);
      st.run <= 1;
   endtask
   task automatic print_verdict;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      print_verdict();
   end
   initial begin
      void'($urandom(20336));
      p = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(4'h0, 32'h80000000, 32'hc000000f);
      rd(4'h4, 32'h0, 32'h3, 2);
      rd(4'hc, 32'h2, 32'hffff);
      rd(4'h2, 32'h0, 32'hffffffff);
      wr(4'h2, 32'h5);
      check("bresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
      wr(4'h0, 32'h5, 4'h0);
      rd(4'h0, 32'h0, 32'hf);
      $display("test registers done");
      wr(4'h0, 32'h5);
      wr(4'h4, 32'h1);
      wr(4'h8, 32'h64);
      pv(16'd200, 0);
      pv(16'd0, 0);
      pv(16'd200, 1);
      run_cycle();
      pv(16'd200, 0);
      pv(16'd0, 0);
      pv(16'd200, 1);
      p.control_setpoint = 16'd50;
      smp(1);
      wr(4'h4, 32'h2);
      p.control_setpoint = 16'd60;
      smp(0);
      pv(16'd0, 0);
      pv(16'd200, 1);
      for (int i = 0; i < 2; i++) begin
         st.rate_limiter_on <= (i == 0);
         st.remote_mode <= (i == 1);
         p.control_setpoint = 16'd70 + 16'(i);
         smp(1);
         run_cycle();
         pv(16'd200, 0);
         pv(16'd0, 0);
         pv(16'd200, 1);
      end
      st.rate_limiter_on <= 0;
      st.remote_mode <= 0;
      wr(4'h0, 32'h7);
      run_cycle();
      p.control_setpoint = 16'd200;
      smp(1);
      $display("test hold done");
      wr(4'h4, 32'h0);
      wr(4'h0, 32'ha);
      st.fbr_in_use <= 1;
      p = '0;
      p.feedback_resistance_input = 16'd200;
      smp(1);
      p = '0;
      p.heat_side_output = 16'd200;
      smp(0);
      st.fbr_in_use <= 0;
      for (int c = 1; c < 14; c++) begin
         if (c == 9) continue;
         wr(4'h0, c);
         lo = (c inside {2, 6, 8, 11, 13});
         for (int on = 1; on >= 0; on--) begin
            x = ((on != 0) != lo) ? 16'd110 + 16'($urandom_range(0, 200))
                                  : 16'($urandom_range(0, 90));
            p = '0;
            if (c < 7) p.measured_value = x;
            else if (c < 9) p.control_setpoint = x;
            else if (c < 12) p.heat_side_output = x;
            else p.cool_side_output = x;
            smp(on != 0);
         end
      end
      wr(4'h0, 32'h0);
      p = {6{16'h00c8}};
      smp(0);
      $display("test types done");
      wr(4'h0, 32'h5);
      p = '0;
      pv(16'd200, 1);
      pv(16'd99, 1);
      rd(4'h0, 32'h40000000, 32'h40000000, 2);
      pv(16'd97, 0);
      pv(16'd99, 0);
      $display("test gap done");
      print_verdict();
   end
endmodule
bind event_type_hold_logic event_hold_checker chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .status(status), .event_out(event_out));
